/* File: verilog/fsc_consts.svh */
// Purpose: Constants for the fuse and identification service calls
// Assumes: Byte offsets for the requester's software registers
// Notes: Field positions are bit indexes within the 32-bit call word, result word or requester software register
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// Request word fields
`define FSC_OP_MSB 31
`define FSC_OP_LSB 24
`define FSC_DIRECT_BIT 0
`define FSC_HANG_BIT 31
`define FSC_ALIGN_BIT 1
`define FSC_IDTYPE_MSB 15
`define FSC_IDTYPE_LSB 8
`define FSC_BYTE_MSB 23
`define FSC_BYTE_LSB 16
`define FSC_MACRO_MSB 15
`define FSC_MACRO_LSB 12
`define FSC_BIT_MSB 10
`define FSC_BIT_LSB 8
`define FSC_RADDR_MSB 23
`define FSC_RADDR_LSB 8

// Opcodes and identification types
`define FSC_OP_ID 8'h00
`define FSC_OP_BLOW 8'h01
`define FSC_OP_READ 8'h03
`define FSC_IDT_FAMILY 8'h00
`define FSC_IDT_SILICON 8'h01

// Result word status nibble and error codes
`define FSC_STAT_MSB 31
`define FSC_STAT_LSB 28
`define FSC_ST_OK 4'ha
`define FSC_ST_ERR 4'hf
`define FSC_ERR_OPCODE 28'h0000001
`define FSC_ERR_ADDR 28'h0000002
`define FSC_ERR_IDTYPE 28'h0000003
`define FSC_ERR_HANG 28'h0000004
`define FSC_ERR_ALIGN 28'h0000005

// Fuse blow time
`define FSC_CLK_MHZ 200
`define FSC_BLOW_NS 1000
`define FSC_BLOW_CYCLES ((`FSC_BLOW_NS * `FSC_CLK_MHZ + 999) / 1000)

// Requester software registers, byte offsets and bit positions
`define FSC_REG_CTRL 8'h00
`define FSC_REG_REQ 8'h04
`define FSC_REG_PTR 8'h08
`define FSC_REG_RESULT 8'h0c
`define FSC_REG_STATUS 8'h10
`define FSC_REG_MASK 8'h14
`define FSC_CTRL_GO 0
`define FSC_CTRL_SCRATCH 1
`define FSC_IRQ_OK 0
`define FSC_IRQ_ERR 1

`endif

/* File: verilog/fsc_pkg.sv */
// Purpose: Types used by the service end of the service-call link
// Assumes: Constants live in fsc_consts.svh
// Notes: States only
`default_nettype none
package fsc_pkg;

  typedef enum logic [2:0] {
    FSC_IDLE,
    FSC_FETCH,
    FSC_LOAD,
    FSC_EXEC,
    FSC_BLOW,
    FSC_FINISH,
    FSC_DONE
  } fsc_dev_state_t;

endpackage
`default_nettype wire

/* File: verilog/fsc_call_if.sv */
// Purpose: Call word, answer and scratch memory port between the ends
// Assumes: Both ends on core_clk
// Notes: Memory read data stands one cycle after mem_rd
`timescale 1ns/100ps
`default_nettype none
interface fsc_call_if;
  logic call_valid;
  logic [31:0] call_word;
  logic rsp_valid;
  logic [31:0] rsp_word;
  logic mem_rd;
  logic mem_wr;
  logic [31:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;

  modport dev (
    input call_valid, call_word, mem_rdata,
    output rsp_valid, rsp_word, mem_rd, mem_wr, mem_addr, mem_wdata
  );

  modport req (
    output call_valid, call_word, mem_rdata,
    input rsp_valid, rsp_word, mem_rd, mem_wr, mem_addr, mem_wdata
  );
endinterface
`default_nettype wire

/* File: verilog/fsc_service_end.sv */
// Purpose: Service-call engine: identification, fuse blow, fuse byte read
// Assumes: One call at a time; requester waits for rsp_valid
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_service_end #(
  parameter logic [11:0] FAMILY_ID = 12'h0a5,  // Arbitrary value
  parameter logic [15:0] SILICON_ID = 16'h1234,  // Arbitrary value
  parameter logic [3:0] MAJOR_REV = 4'h1,  // Arbitrary value
  parameter logic [3:0] MINOR_REV = 4'h0,  // Arbitrary value
  parameter int FUSE_BYTES = 256,
  parameter int BLOW_CYCLES = `FSC_BLOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  fsc_call_if.dev link,
  input wire logic [3:0] prot_state,
  input wire logic [3:0] life_stage,
  output logic busy,
  output logic blow_active,
  output logic [11:0] blow_byte_index,
  output logic [2:0] blow_bit
);

  localparam int IW = (FUSE_BYTES > 1) ? $clog2(FUSE_BYTES) : 1;
  localparam logic [16:0] FUSE_LIMIT = 17'(FUSE_BYTES);
  localparam logic [15:0] BLOW_LAST = 16'(BLOW_CYCLES - 1);

  fsc_pkg::fsc_dev_state_t state_reg;
  logic scratch_reg;
  logic [31:0] args_reg;
  logic [31:0] result_reg;
  logic [15:0] cnt_reg;
  logic [7:0] fuse_mem [FUSE_BYTES];

  logic [31:0] exec_next;
  logic blow_go;
  logic [7:0] opcode;
  logic [7:0] id_type;
  logic [11:0] blow_idx;
  logic [2:0] blow_sel;
  logic [15:0] read_idx;

  assign opcode = args_reg[`FSC_OP_MSB:`FSC_OP_LSB];
  assign id_type = args_reg[`FSC_IDTYPE_MSB:`FSC_IDTYPE_LSB];
  assign blow_idx = {args_reg[`FSC_MACRO_MSB:`FSC_MACRO_LSB],
                     args_reg[`FSC_BYTE_MSB:`FSC_BYTE_LSB]};
  assign blow_sel = args_reg[`FSC_BIT_MSB:`FSC_BIT_LSB];
  assign read_idx = args_reg[`FSC_RADDR_MSB:`FSC_RADDR_LSB];

  // Result of the decoded call
  always_comb begin
    exec_next = {`FSC_ST_ERR, `FSC_ERR_OPCODE};
    blow_go = 1'b0;
    case (opcode)
      `FSC_OP_ID: begin
        if (id_type == `FSC_IDT_FAMILY) begin
          exec_next = {`FSC_ST_OK, 4'h0, MAJOR_REV, MINOR_REV,
                       4'h0, FAMILY_ID};
        end else if (id_type == `FSC_IDT_SILICON) begin
          exec_next = {`FSC_ST_OK, 4'h0, life_stage, prot_state,
                       SILICON_ID};
        end else begin
          exec_next = {`FSC_ST_ERR, `FSC_ERR_IDTYPE};
        end
      end
      `FSC_OP_BLOW: begin
        if ({5'h00, blow_idx} < FUSE_LIMIT) begin
          exec_next = {`FSC_ST_OK, 28'h0000000};
          blow_go = 1'b1;
        end else begin
          exec_next = {`FSC_ST_ERR, `FSC_ERR_ADDR};
        end
      end
      `FSC_OP_READ: begin
        if ({1'b0, read_idx} < FUSE_LIMIT) begin
          exec_next = {`FSC_ST_OK, 4'h0, 16'h0000,
                       fuse_mem[read_idx[IW-1:0]]};
        end else begin
          exec_next = {`FSC_ST_ERR, `FSC_ERR_ADDR};
        end
      end
      default: begin
        exec_next = {`FSC_ST_ERR, `FSC_ERR_OPCODE};
      end
    endcase
  end

  // Call sequencing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= fsc_pkg::FSC_IDLE;
      scratch_reg <= 1'b0;
      args_reg <= 32'h00000000;
      result_reg <= 32'h00000000;
      cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        fsc_pkg::FSC_IDLE: begin
          if (link.call_valid) begin
            scratch_reg <= 1'b0;
            if (link.call_word[`FSC_DIRECT_BIT]) begin
              if (link.call_word[`FSC_HANG_BIT]) begin
                // Pointer taken as direct word would hang
                result_reg <= {`FSC_ST_ERR, `FSC_ERR_HANG};
                state_reg <= fsc_pkg::FSC_FINISH;
              end else begin
                args_reg <= link.call_word;
                state_reg <= fsc_pkg::FSC_EXEC;
              end
            end else if (link.call_word[`FSC_ALIGN_BIT]) begin
              result_reg <= {`FSC_ST_ERR, `FSC_ERR_ALIGN};
              state_reg <= fsc_pkg::FSC_FINISH;
            end else begin
              scratch_reg <= 1'b1;
              state_reg <= fsc_pkg::FSC_FETCH;
            end
          end
        end
        fsc_pkg::FSC_FETCH: begin
          state_reg <= fsc_pkg::FSC_LOAD;
        end
        fsc_pkg::FSC_LOAD: begin
          args_reg <= link.mem_rdata;
          state_reg <= fsc_pkg::FSC_EXEC;
        end
        fsc_pkg::FSC_EXEC: begin
          result_reg <= exec_next;
          cnt_reg <= BLOW_LAST;
          if (blow_go) begin
            state_reg <= fsc_pkg::FSC_BLOW;
          end else begin
            state_reg <= fsc_pkg::FSC_FINISH;
          end
        end
        fsc_pkg::FSC_BLOW: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= fsc_pkg::FSC_FINISH;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        fsc_pkg::FSC_FINISH: begin
          state_reg <= fsc_pkg::FSC_DONE;
        end
        fsc_pkg::FSC_DONE: begin
          state_reg <= fsc_pkg::FSC_IDLE;
        end
        default: begin
          state_reg <= fsc_pkg::FSC_IDLE;
        end
      endcase
    end
  end

  // Fuse array, nonvolatile in a real macro
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < FUSE_BYTES; i++) begin
        fuse_mem[i] <= 8'h00;
      end
    end else if (state_reg == fsc_pkg::FSC_BLOW && cnt_reg == 16'h0000) begin
      fuse_mem[blow_idx[IW-1:0]][blow_sel] <= 1'b1;
    end
  end

  // Scratch memory port
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link.mem_rd <= 1'b0;
      link.mem_wr <= 1'b0;
      link.mem_addr <= 32'h00000000;
      link.mem_wdata <= 32'h00000000;
    end else begin
      link.mem_rd <= state_reg == fsc_pkg::FSC_IDLE && link.call_valid &&
                     !link.call_word[`FSC_DIRECT_BIT] &&
                     !link.call_word[`FSC_ALIGN_BIT];
      if (state_reg == fsc_pkg::FSC_IDLE && link.call_valid) begin
        link.mem_addr <= link.call_word;
      end
      link.mem_wr <= state_reg == fsc_pkg::FSC_FINISH && scratch_reg;
      link.mem_wdata <= result_reg;
    end
  end

  // Answer and user-side status
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_word <= 32'h00000000;
      busy <= 1'b0;
      blow_active <= 1'b0;
      blow_byte_index <= 12'h000;
      blow_bit <= 3'h0;
    end else begin
      link.rsp_valid <= state_reg == fsc_pkg::FSC_DONE;
      if (state_reg == fsc_pkg::FSC_DONE) begin
        link.rsp_word <= result_reg;
      end
      busy <= state_reg != fsc_pkg::FSC_IDLE || link.call_valid;
      blow_active <= state_reg == fsc_pkg::FSC_BLOW;
      blow_byte_index <= blow_idx;
      blow_bit <= blow_sel;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/fsc_request_end.sv */
// Purpose: Requester that issues service calls for software
// Assumes: Plain register port, read data one cycle after the strobe
// Notes: Holds the scratch words the engine reads and writes
`timescale 1ns/100ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_request_end #(
  parameter int SCRATCH_WORDS = 4,
  parameter logic [31:0] SCRATCH_BASE = 32'h08000000
) (
  input wire logic core_clk,
  input wire logic resetn,
  fsc_call_if.req link,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic irq
);

  localparam int XW = (SCRATCH_WORDS > 1) ? $clog2(SCRATCH_WORDS) : 1;

  logic [31:0] scratch_mem [SCRATCH_WORDS];
  logic [31:0] req_reg;
  logic [XW-1:0] ptr_reg;
  logic mode_reg;
  logic busy_reg;
  logic [31:0] result_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic go;
  logic [31:0] rsp_now;
  logic [1:0] stat_set;
  logic [1:0] stat_clr;
  logic [XW-1:0] mem_idx;

  assign go = sw_wr && sw_addr == `FSC_REG_CTRL &&
              sw_wdata[`FSC_CTRL_GO] && !busy_reg;
  assign mem_idx = link.mem_addr[XW+1:2];
  assign rsp_now = mode_reg ? scratch_mem[ptr_reg] : link.rsp_word;
  assign stat_set[`FSC_IRQ_OK] = link.rsp_valid &&
    rsp_now[`FSC_STAT_MSB:`FSC_STAT_LSB] == `FSC_ST_OK;
  assign stat_set[`FSC_IRQ_ERR] = link.rsp_valid &&
    rsp_now[`FSC_STAT_MSB:`FSC_STAT_LSB] != `FSC_ST_OK;
  assign stat_clr = (sw_wr && sw_addr == `FSC_REG_STATUS) ?
                    sw_wdata[1:0] : 2'h0;

  // Software registers and call issue
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      req_reg <= 32'h00000000;
      ptr_reg <= '0;
      mode_reg <= 1'b0;
      busy_reg <= 1'b0;
      result_reg <= 32'h00000000;
      mask_reg <= 2'h0;
      link.call_valid <= 1'b0;
      link.call_word <= 32'h00000000;
    end else begin
      link.call_valid <= go;
      if (sw_wr && sw_addr == `FSC_REG_REQ) begin
        req_reg <= sw_wdata;
      end
      if (sw_wr && sw_addr == `FSC_REG_PTR && !busy_reg) begin
        ptr_reg <= sw_wdata[XW-1:0];
      end
      if (sw_wr && sw_addr == `FSC_REG_MASK) begin
        mask_reg <= sw_wdata[1:0];
      end
      if (go) begin
        mode_reg <= sw_wdata[`FSC_CTRL_SCRATCH];
        busy_reg <= 1'b1;
        if (sw_wdata[`FSC_CTRL_SCRATCH]) begin
          link.call_word <= SCRATCH_BASE |
            32'({ptr_reg, 2'b00});
        end else begin
          link.call_word <= {req_reg[31:1], 1'b1};
        end
      end else if (link.rsp_valid) begin
        busy_reg <= 1'b0;
        result_reg <= rsp_now;
      end
    end
  end

  // Scratch words, read data one cycle after mem_rd
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SCRATCH_WORDS; i++) begin
        scratch_mem[i] <= 32'h00000000;
      end
      link.mem_rdata <= 32'h00000000;
    end else begin
      if (go && sw_wdata[`FSC_CTRL_SCRATCH]) begin
        scratch_mem[ptr_reg] <= req_reg;
      end else if (link.mem_wr) begin
        scratch_mem[mem_idx] <= link.mem_wdata;
      end
      if (link.mem_rd) begin
        link.mem_rdata <= scratch_mem[mem_idx];
      end
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stat_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      irq <= |(((stat_reg & ~stat_clr) | stat_set) & mask_reg);
    end
  end

  // Read port
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sw_rdata <= 32'h00000000;
    end else if (sw_rd) begin
      case (sw_addr)
        `FSC_REG_CTRL: sw_rdata <= {30'h0, mode_reg, busy_reg};
        `FSC_REG_REQ: sw_rdata <= req_reg;
        `FSC_REG_PTR: sw_rdata <= 32'(ptr_reg);
        `FSC_REG_RESULT: sw_rdata <= result_reg;
        `FSC_REG_STATUS: sw_rdata <= {30'h0, stat_reg};
        `FSC_REG_MASK: sw_rdata <= {30'h0, mask_reg};
        default: sw_rdata <= 32'h00000000;
      endcase
    end else begin
      sw_rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

/* File: testbench/fsc_link_asserts.sv */
// Purpose: Checks on the call link between the two ends
// Assumes: One clock, reset active low
// Notes: Latencies follow the hand-over figures
`timescale 1ns/100ps
`default_nettype none
module fsc_link_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic call_valid,
  input wire logic [31:0] call_word,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_word,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_direct;
    call_valid && call_word[0] && !call_word[31];
  endsequence
  sequence s_quick;
    s_direct ##0 (call_word[31:24] == 8'h00 || call_word[31:24] == 8'h03);
  endsequence
  sequence s_scratch;
    call_valid && call_word[1:0] == 2'h0;
  endsequence
  AST_STATUS: assert property (rsp_valid |->
    rsp_word[31:28] == 4'ha || rsp_word[31:28] == 4'hf)
    else $error("status nibble not a or f");
  AST_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  AST_HOLD: assert property ($changed(rsp_word) |-> rsp_valid)
    else $error("result changed without answer");
  AST_FETCH: assert property (s_scratch |=>
    mem_rd && mem_addr == $past(call_word))
    else $error("scratch word not fetched");
  AST_DIRECT: assert property (s_direct |=>
    (!mem_rd && !mem_wr)[*4])
    else $error("direct call touched scratch");
  AST_QUICK: assert property (s_quick |-> ##4 rsp_valid)
    else $error("direct answer late");
  AST_HANG: assert property (call_valid && call_word[0] && call_word[31]
    |-> ##3 (rsp_valid && rsp_word == 32'hf0000004))
    else $error("hang case not refused");
  AST_WRBACK: assert property (mem_wr |=>
    rsp_valid && rsp_word == $past(mem_wdata))
    else $error("answer differs from written back");
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Both ends joined, driven through the register port
// Assumes: Short blow time
// Notes: Fuse image kept here to predict reads
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [11:0] FAM = 12'h3c7;
  localparam logic [15:0] SIL = 16'h5e21;
  localparam logic [3:0] MAJ = 4'h2;
  localparam logic [3:0] MIN = 4'h6;
  localparam int BLOW_N = 2;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic irq;
  logic [3:0] prot_state = 4'h0;
  logic [3:0] life_stage = 4'h0;
  logic busy;
  logic blow_active;
  logic [11:0] blow_byte_index;
  logic [2:0] blow_bit;
  logic [7:0] fuse [256];
  logic [31:0] masks [4] = '{32'h1ff, 32'hff17ff, 32'h1ffff, 32'hffffff};
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  fsc_call_if link ();
  fsc_service_end #(.FAMILY_ID(FAM), .SILICON_ID(SIL), .MAJOR_REV(MAJ),
    .MINOR_REV(MIN), .BLOW_CYCLES(BLOW_N)) i_fsc_service_end (
    .core_clk(core_clk), .resetn(resetn), .link(link),
    .prot_state(prot_state), .life_stage(life_stage), .busy(busy),
    .blow_active(blow_active), .blow_byte_index(blow_byte_index),
    .blow_bit(blow_bit));
  fsc_request_end i_fsc_request_end (.core_clk(core_clk), .resetn(resetn),
    .link(link), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  fsc_link_asserts i_fsc_link_asserts (.core_clk(core_clk),
    .resetn(resetn), .call_valid(link.call_valid),
    .call_word(link.call_word), .rsp_valid(link.rsp_valid),
    .rsp_word(link.rsp_word), .mem_rd(link.mem_rd), .mem_wr(link.mem_wr),
    .mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata));
  always #2.5 core_clk = ~core_clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  function automatic logic [31:0] expect_of(input logic [31:0] a,
    input bit direct, input logic [3:0] p, input logic [3:0] l);
    if (direct && a[31]) return 32'hf0000004;
    case (a[31:24])
      8'h00: begin
        if (a[15:8] == 8'h00) return {8'ha0, MAJ, MIN, 4'h0, FAM};
        if (a[15:8] == 8'h01) return {8'ha0, l, p, SIL};
        return 32'hf0000003;
      end
      8'h01: return a[15:12] != 4'h0 ? 32'hf0000002 : 32'ha0000000;
      8'h03: begin
        if (a[23:16] != 8'h00) return 32'hf0000002;
        return {24'ha00000, fuse[a[15:8]]};
      end
      default: return 32'hf0000001;
    endcase
  endfunction
  task automatic call(input logic [31:0] a, input bit direct);
    logic [31:0] e;
    logic [31:0] g;
    logic [3:0] p;
    logic [3:0] l;
    int n;
    int nb;
    logic [14:0] bi;
    bit bz;
    bit blown;
    p = 4'($urandom_range(4));
    l = 4'($urandom_range(4));
    prot_state <= p;
    life_stage <= l;
    e = expect_of(a, direct, p, l);
    blown = a[31:24] == 8'h01 && e[31:28] == 4'ha;
    if (direct) begin
      wr(8'h04, a | 32'h1);
    end else begin
      wr(8'h08, 32'($urandom_range(3)));
      wr(8'h04, a);
    end
    wr(8'h00, direct ? 32'h1 : 32'h3);
    n = 0;
    nb = 0;
    bi = 15'h0;
    bz = 1'b0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
      if (busy === 1'b1) bz = 1'b1;
      if (blow_active === 1'b1) begin
        nb++;
        bi = {blow_bit, blow_byte_index};
      end
    end
    if (n >= 400) error_cnt++;
    rd(8'h0c, g);
    check("result", e, g);
    rd(8'h10, g);
    check("status", e[31:28] == 4'ha ? 32'h1 : 32'h2, g);
    check("busy seen", 32'h1, {31'h0, bz});
    check("busy idle", 32'h0, {31'h0, busy});
    check("blow cycles", blown ? 32'(BLOW_N) : 32'h0, nb);
    if (blown) begin
      check("blow address", {17'h0, a[10:8], a[15:12], a[23:16]},
            {17'h0, bi});
    end
    wr(8'h10, 32'h3);
    if (blown)
      fuse[a[23:16]][a[10:8]] = 1'b1;
  endtask
  initial begin
    logic [31:0] v;
    logic [31:0] a;
    void'($urandom(32'ha1e1));
    foreach (fuse[i]) fuse[i] = 8'h00;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rd(8'h14, v);
    check("mask", 32'h0, v);
    wr(8'h30, 32'hffffffff);
    rd(8'h30, v);
    check("unmapped", 32'h0, v);
    wr(8'h04, 32'h00000001);
    wr(8'h00, 32'h1);
    repeat (12) @(posedge core_clk);
    check("masked irq", 32'h0, {31'h0, irq});
    wr(8'h14, 32'h3);
    repeat (2) @(posedge core_clk);
    check("irq", 32'h1, {31'h0, irq});
    wr(8'h10, 32'h3);
    repeat (2) @(posedge core_clk);
    check("irq clear", 32'h0, {31'h0, irq});
    $display("test registers done");
    for (int t = 0; t < 4; t++) begin
      call({16'h0000, 8'(t / 2), 8'($urandom)}, t[0]);
    end
    call(32'h00000201, 1'b1);
    call(32'h81000001, 1'b1);
    $display("test identification done");
    call(32'h01ff0701, 1'b1);
    call(32'h01ff0701, 1'b0);
    call(32'h0300ff5a, 1'b0);
    call(32'h0300ff01, 1'b1);
    call(32'h01001001, 1'b1);
    call(32'h03010001, 1'b1);
    $display("test fuse edges done");
    for (int i = 0; i < 40; i++) begin
      v = 32'($urandom_range(3));
      a = $urandom & masks[v];
      a[31:24] = v == 3 ? 8'h02 : 8'(v == 2 ? 3 : v);
      call(a, 1'($urandom));
    end
    $display("test random calls done");
    print_verdict();
  end
endmodule
`default_nettype wire
